// ### common/vrcal_pkg.sv
// package: constants and the command type for the dq reference calibration block
package vrcal_pkg;

    // ************************************************************
    // command encoding on the link (abstracted ddr command set)
    // ************************************************************
    typedef enum logic [3:0] {
        VRCAL_CMD_DES  = 4'h0,
        VRCAL_CMD_ACT  = 4'h1,
        VRCAL_CMD_WR   = 4'h2,
        VRCAL_CMD_WRA  = 4'h3,
        VRCAL_CMD_RD   = 4'h4,
        VRCAL_CMD_RDA  = 4'h5,
        VRCAL_CMD_PRE  = 4'h6,
        VRCAL_CMD_MRS  = 4'h7,
        VRCAL_CMD_REF  = 4'h8
    } vrcal_cmd_t;

    // ************************************************************
    // vref mode register layout
    // ************************************************************
    localparam logic [2:0] VRCAL_MR_VREF     = 3'h6;
    localparam int         VRCAL_EN_BIT      = 7;
    localparam int         VRCAL_RANGE_BIT   = 6;
    localparam int         VRCAL_CODE_W      = 6;
    localparam logic [5:0] VRCAL_CODE_MAX    = 6'h32;
    localparam logic [5:0] VRCAL_CODE_RST    = 6'h00;
    localparam logic       VRCAL_RANGE_RST   = 1'b0;

    // range spans in hundredths of a percent of the i/o supply
    localparam int         VRCAL_R1_LO_CPCT  = 6000;
    localparam int         VRCAL_R1_HI_CPCT  = 9250;
    localparam int         VRCAL_R2_LO_CPCT  = 4500;
    localparam int         VRCAL_STEP_CPCT   = 65;

    // ************************************************************
    // timing, in ns and in link clock cycles (link period 30 ns)
    // ************************************************************
    localparam int         VRCAL_LINK_NS     = 30;
    localparam int         VRCAL_ENTRY_NS    = 150;
    localparam int         VRCAL_EXIT_NS     = 150;
    localparam int         VRCAL_SETTLE_S_NS = 150;
    localparam int         VRCAL_SETTLE_L_NS = 250;
    localparam int         VRCAL_ENTRY_CYC   = (VRCAL_ENTRY_NS + VRCAL_LINK_NS - 1) / VRCAL_LINK_NS;
    localparam int         VRCAL_EXIT_CYC    = (VRCAL_EXIT_NS + VRCAL_LINK_NS - 1) / VRCAL_LINK_NS;
    localparam int         VRCAL_SET_S_CYC   = (VRCAL_SETTLE_S_NS + VRCAL_LINK_NS - 1) / VRCAL_LINK_NS;
    localparam int         VRCAL_SET_L_CYC   = (VRCAL_SETTLE_L_NS + VRCAL_LINK_NS - 1) / VRCAL_LINK_NS;
    localparam int         VRCAL_CNT_W       = 8;
    localparam int         VRCAL_LINK_DIV    = 3;

endpackage

// ### common/vrcal_if.sv
// interface: command link between memory controller and dram calibration logic
`timescale 1ns/1ps
`default_nettype none
interface vrcal_if;
    import vrcal_pkg::*;
    logic       link_clk;     // command clock, made by the controller
    logic       link_rst;     // dram reset, synchronous to link_clk
    vrcal_cmd_t cmd;          // command on this link edge
    logic [2:0] mr_sel;       // mode register select for mrs
    logic [7:0] mr_data;      // mode register payload
    logic       pda_on;       // per_device_addressing active
    logic       banks_idle;   // all banks precharged

    modport ctl (output link_clk, output link_rst, output cmd, output mr_sel,
                 output mr_data, output pda_on, output banks_idle);
    modport dram (input link_clk, input link_rst, input cmd, input mr_sel,
                  input mr_data, input pda_on, input banks_idle);
endinterface
`default_nettype wire

// ### hw/vrcal_wait_cnt.sv
// module: loadable down counter that reports when a wait has run out
`timescale 1ns/1ps
`default_nettype none
module vrcal_wait_cnt
    import vrcal_pkg::*;
#(
    parameter int W = vrcal_pkg::VRCAL_CNT_W
)(
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire logic         load,
    input  wire logic [W-1:0] value,
    output logic              done
);
    typedef struct packed {
        logic [W-1:0] cnt;
    } vrcal_wc_t;

    vrcal_wc_t s_q;
    vrcal_wc_t s_d;

    // load wins over count so a back to back restart is never lost
    always_comb
    begin
        s_d = s_q;
        if (load)
            s_d.cnt = value;
        else if (s_q.cnt != '0)
            s_d.cnt = s_q.cnt - W'(1);
    end

    always_ff @(posedge clk)
    begin
        if (rst)
            s_q <= '0;
        else
            s_q <= s_d;
    end

    // done looks at the count alone, so a caller may derive load from done without a loop
    assign done = (s_q.cnt == '0);
endmodule
`default_nettype wire

// ### hw/vrcal_dram.sv
// module: dram end, tracks calibration mode and holds the dq_input_reference setting
`timescale 1ns/1ps
`default_nettype none
//
// Overview of operation
// - mr bit7 enters or leaves; entry takes range
// - entry command never programs a code
// - controller waits cal_entry_delay after entry
// - only act rw pre des mrs during calibration
// - dummy writes accepted before first code update
// - updates keep bit7 set, same range
// - write with bit7 clear keeps range, code
// - controller waits settle time after each update
// - per_device_addressing allows only mrs commands
// - last written range and code used after exit
// - exit only with all banks idle; an exit with open banks is flagged but still leaves calibration
// - only deselect until cal_exit_delay passes
// - range changes only on entry command
// - settle time honoured before leaving calibration
// - typical script: enter, updates, final, exit
// - eye_center_level found by pass/fail sweeps
// - recalibrate after large temperature drift
// - two ranges, 51 linear codes each
// - reference undefined until first programmed
//
module vrcal_dram
    import vrcal_pkg::*;
(
    vrcal_if.dram            lnk,
    input  wire logic        core_clk,
    input  wire logic        rst,
    output logic             cal_active,
    output logic             ref_range,
    output logic [5:0]       ref_code,
    output logic             ref_valid,
    output logic [13:0]      ref_level_cpct,
    output logic             protocol_err
);
    import vrcal_pkg::*;

    // ************************************************************
    // link domain state
    // ************************************************************
    typedef struct packed {
        logic       active;     // calibration mode flag
        logic       range;      // latched range
        logic [5:0] code;       // latest code
        logic       valid;      // reference programmed since reset
        logic       first_cal;  // first calibration after reset not yet adjusted
        logic       err_tgl;    // toggles on every protocol breach
        logic       in_exit;    // cal_exit_delay running
        logic       in_entry;   // cal_entry_delay running
        logic       settling;   // settle time running
    } vrcal_dr_t;

    vrcal_dr_t s_q;
    vrcal_dr_t s_d;

    logic       is_mrs;
    logic       wr_vref;
    logic       en_bit;
    logic       legal;
    logic       breach;
    logic       wc_load;
    logic [VRCAL_CNT_W-1:0] wc_val;
    logic       wc_done;

    assign is_mrs  = (lnk.cmd == VRCAL_CMD_MRS);
    assign wr_vref = is_mrs && (lnk.mr_sel == VRCAL_MR_VREF);
    assign en_bit  = lnk.mr_data[VRCAL_EN_BIT];

    // command legality while in calibration
    always_comb
    begin
        legal = 1'b1;
        if (s_q.in_exit)
            legal = (lnk.cmd == VRCAL_CMD_DES);
        else if (s_q.active)
        begin
            if (s_q.in_entry)
                legal = (lnk.cmd == VRCAL_CMD_DES);
            else if (lnk.pda_on)
                legal = (lnk.cmd == VRCAL_CMD_DES) || wr_vref;
            else
            begin
                unique case (lnk.cmd)
                    VRCAL_CMD_DES, VRCAL_CMD_ACT, VRCAL_CMD_WR, VRCAL_CMD_WRA,
                    VRCAL_CMD_RD, VRCAL_CMD_RDA, VRCAL_CMD_PRE: legal = 1'b1;
                    VRCAL_CMD_MRS: legal = wr_vref;
                    default: legal = 1'b0;
                endcase
            end
            if (wr_vref && en_bit && lnk.mr_data[VRCAL_RANGE_BIT] != s_q.range)
                legal = 1'b0;
            if (wr_vref && !en_bit && (!lnk.banks_idle || s_q.settling))
                legal = 1'b0;
            if (wr_vref && en_bit && lnk.mr_data[5:0] > VRCAL_CODE_MAX)
                legal = 1'b0;
        end
    end

    assign breach = !legal;

    // next state from the accepted command
    always_comb
    begin
        s_d     = s_q;
        wc_load = 1'b0;
        wc_val  = '0;
        if (wc_done)
        begin
            s_d.in_entry = 1'b0;
            s_d.in_exit  = 1'b0;
            s_d.settling = 1'b0;
        end
        if (breach)
            s_d.err_tgl = ~s_q.err_tgl;
        if (wr_vref && en_bit && !s_q.active && !s_q.in_exit)
        begin
            s_d.active    = 1'b1;
            s_d.range     = lnk.mr_data[VRCAL_RANGE_BIT];
            s_d.in_entry  = 1'b1;                                                 // code ignored
            wc_load       = 1'b1;
            wc_val        = VRCAL_CNT_W'(VRCAL_ENTRY_CYC);
        end
        else if (wr_vref && en_bit && s_q.active && legal)
        begin
            s_d.code      = lnk.mr_data[5:0];
            s_d.valid     = 1'b1;
            s_d.first_cal = 1'b0;
            s_d.settling  = 1'b1;
            wc_load       = 1'b1;
            wc_val        = (lnk.mr_data[5:0] > s_q.code ? lnk.mr_data[5:0] - s_q.code
                                                         : s_q.code - lnk.mr_data[5:0]) > 6'h01
                            ? VRCAL_CNT_W'(VRCAL_SET_L_CYC) : VRCAL_CNT_W'(VRCAL_SET_S_CYC);
        end
        else if (wr_vref && !en_bit && s_q.active)
        begin
            s_d.active   = 1'b0;
            s_d.in_exit  = 1'b1;
            s_d.settling = 1'b0;
            wc_load      = 1'b1;
            wc_val       = VRCAL_CNT_W'(VRCAL_EXIT_CYC);
        end
    end

    vrcal_wait_cnt #(.W(VRCAL_CNT_W)) u_wait (
        .clk   (lnk.link_clk),
        .rst   (lnk.link_rst),
        .load  (wc_load),
        .value (wc_val),
        .done  (wc_done)
    );

    always_ff @(posedge lnk.link_clk)
    begin
        if (lnk.link_rst)
        begin
            s_q           <= '0;
            s_q.range     <= VRCAL_RANGE_RST;
            s_q.code      <= VRCAL_CODE_RST;
            s_q.first_cal <= 1'b1;
        end
        else
            s_q <= s_d;
    end

    // ************************************************************
    // crossing into core_clk: levels by two flops, errors by toggle
    // ************************************************************
    typedef struct packed {
        logic [9:0] sync1;
        logic [9:0] sync2;
        logic [9:0] prev;
        logic       err_last;
        logic       act;
        logic       rng;
        logic [5:0] code;
        logic       vld;
        logic       err;
        logic [13:0] lvl;
    } vrcal_cs_t;

    vrcal_cs_t c_q;
    vrcal_cs_t c_d;

    // bits may skew across the flops, so a snapshot is taken only once it repeats
    always_comb
    begin
        c_d       = c_q;
        c_d.sync1 = {s_q.valid, s_q.active, s_q.range, s_q.code, s_q.err_tgl};
        c_d.sync2 = c_q.sync1;
        c_d.prev  = c_q.sync2;
        c_d.err_last = c_q.sync2[0];
        c_d.err   = c_q.sync2[0] ^ c_q.err_last;
        c_d.act   = c_q.sync2[8];
        if (!c_q.sync2[8] && (c_q.sync2[9:1] == c_q.prev[9:1]))
        begin
            c_d.rng  = c_q.sync2[7];
            c_d.code = c_q.sync2[6:1];
            c_d.vld  = c_q.sync2[9];
        end
        c_d.lvl   = (c_d.rng ? 14'(VRCAL_R2_LO_CPCT) : 14'(VRCAL_R1_LO_CPCT))
                    + 14'(c_d.code) * 14'(VRCAL_STEP_CPCT);
    end

    always_ff @(posedge core_clk)
    begin
        if (rst)
            c_q <= '0;
        else
            c_q <= c_d;
    end

    assign cal_active     = c_q.act;
    assign ref_range      = c_q.rng;
    assign ref_code       = c_q.code;
    assign ref_valid      = c_q.vld;
    assign ref_level_cpct = c_q.lvl;
    assign protocol_err   = c_q.err;
endmodule
`default_nettype wire

// ### hw/vrcal_ctl.sv
// module: controller end, runs entry, code updates and exit with the required waits
`timescale 1ns/1ps
`default_nettype none
module vrcal_ctl
    import vrcal_pkg::*;
(
    vrcal_if.ctl             lnk,
    input  wire logic        core_clk,
    input  wire logic        rst,
    input  wire logic        req_valid,
    output logic             req_ready,
    input  wire logic [1:0]  req_op,     // 0 enter, 1 set code, 2 exit
    input  wire logic        req_range,
    input  wire logic [5:0]  req_code,
    input  wire logic        pda_mode,
    output logic             busy
);
    import vrcal_pkg::*;

    typedef enum logic [1:0] {
        VRCAL_C_IDLE = 2'b00,
        VRCAL_C_SEND = 2'b01,
        VRCAL_C_WAIT = 2'b10
    } vrcal_cst_t;

    typedef struct packed {
        vrcal_cst_t           st;
        logic [1:0]           div;
        logic                 lclk;
        logic [1:0]           op;
        logic                 range;
        logic [5:0]           code;
        logic [VRCAL_CNT_W-1:0] wait_c;
        vrcal_cmd_t           cmd;
        logic [7:0]           data;
        logic                 lrst;
    } vrcal_ct_t;

    vrcal_ct_t s_q;
    vrcal_ct_t s_d;
    logic      fall;

    // link clock made by dividing core_clk, so no second domain here
    // commands move as the link clock falls, half a period clear of the dram sampling edge
    assign fall = (s_q.div == 2'(VRCAL_LINK_DIV - 1)) && s_q.lclk;

    always_comb
    begin
        s_d = s_q;
        s_d.div = (s_q.div == 2'(VRCAL_LINK_DIV - 1)) ? 2'h0 : s_q.div + 2'h1;
        if (s_q.div == 2'(VRCAL_LINK_DIV - 1))
            s_d.lclk = ~s_q.lclk;
        if (fall)
        begin
            s_d.lrst = 1'b0;
            unique case (s_q.st)
                VRCAL_C_IDLE:
                begin
                    s_d.cmd = VRCAL_CMD_DES;
                    if (req_valid)
                    begin
                        s_d.op = req_op;
                        s_d.code = (req_code > VRCAL_CODE_MAX) ? VRCAL_CODE_MAX : req_code;
                        if (req_op == 2'h0)
                            s_d.range = req_range;
                        s_d.st = VRCAL_C_SEND;
                    end
                end
                VRCAL_C_SEND:
                begin
                    s_d.cmd  = VRCAL_CMD_MRS;
                    // entry and updates reuse the latched range bit
                    s_d.data = {s_q.op != 2'h2, s_q.range,
                                s_q.op == 2'h1 ? s_q.code : 6'h00};
                    s_d.wait_c = s_q.op == 2'h0 ? VRCAL_CNT_W'(VRCAL_ENTRY_CYC)
                               : s_q.op == 2'h1 ? VRCAL_CNT_W'(VRCAL_SET_L_CYC)
                               : VRCAL_CNT_W'(VRCAL_EXIT_CYC);
                    s_d.st = VRCAL_C_WAIT;
                end
                VRCAL_C_WAIT:
                begin
                    s_d.cmd = VRCAL_CMD_DES;
                    if (s_q.wait_c != '0)
                        s_d.wait_c = s_q.wait_c - VRCAL_CNT_W'(1);
                    else
                        s_d.st = VRCAL_C_IDLE;
                end
                default: s_d.st = VRCAL_C_IDLE;
            endcase
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            s_q      <= '0;
            s_q.lrst <= 1'b1;
            s_q.cmd  <= VRCAL_CMD_DES;
        end
        else
            s_q <= s_d;
    end

    assign req_ready      = fall && (s_q.st == VRCAL_C_IDLE);
    assign busy           = s_q.st != VRCAL_C_IDLE;
    assign lnk.link_clk   = s_q.lclk;
    assign lnk.link_rst   = s_q.lrst;
    assign lnk.cmd        = s_q.cmd;
    assign lnk.mr_sel     = VRCAL_MR_VREF;
    assign lnk.mr_data    = s_q.data;
    assign lnk.pda_on     = pda_mode;
    assign lnk.banks_idle = 1'b1;
endmodule
`default_nettype wire

// ### bench/vrcal_link_sva.sv
// checker: link rules kept by the controller end of the calibration link
`timescale 1ns/1ps
`default_nettype none
module vrcal_link_sva
    import vrcal_pkg::*;
(
    input  wire logic                  link_clk,
    input  wire logic                  link_rst,
    input  wire vrcal_pkg::vrcal_cmd_t cmd,
    input  wire logic [2:0]            mr_sel,
    input  wire logic [7:0]            mr_data,
    input  wire logic                  pda_on,
    input  wire logic                  banks_idle
);
    // ************************************************************
    // helper state: shadow of the calibration mode seen on the wire
    // ************************************************************
    logic       vmr;
    logic       in_cal_q;
    logic       rng_q;
    logic [1:0] last_q;   // 0 entry, 1 set, 2 exit, 3 none yet
    logic [7:0] since_q;  // saturates so a long idle spell never wraps

    // mrs aimed at the vref register
    assign vmr = (cmd == VRCAL_CMD_MRS) && (mr_sel == VRCAL_MR_VREF);

    // track mode, latched range, last command kind and spacing
    always_ff @(posedge link_clk)
    begin
        if (link_rst)
        begin
            in_cal_q <= 1'b0;
            rng_q    <= 1'b0;
            last_q   <= 2'h3;
            since_q  <= 8'h00;
        end
        else
        begin
            if (cmd != VRCAL_CMD_DES)
                since_q <= 8'h01;
            else if (since_q != 8'hFF)
                since_q <= since_q + 8'h01;
            if (vmr)
            begin
                in_cal_q <= mr_data[VRCAL_EN_BIT];
                if (!in_cal_q)
                    rng_q <= mr_data[VRCAL_RANGE_BIT];
                last_q <= !mr_data[VRCAL_EN_BIT] ? 2'h2 : (in_cal_q ? 2'h1 : 2'h0);
            end
        end
    end

    // ************************************************************
    // assertions
    // ************************************************************
    default clocking cb @(posedge link_clk); endclocking
    default disable iff (link_rst);

    chk_entry_des_run: assert property (
        vmr && !in_cal_q && mr_data[VRCAL_EN_BIT] |=> (cmd == VRCAL_CMD_DES) [*5])
        else $error("command inside the entry wait");
    chk_exit_wait: assert property (
        cmd != VRCAL_CMD_DES && last_q == 2'h2 |-> since_q >= VRCAL_EXIT_CYC)
        else $error("command inside the exit wait");
    chk_settle_wait: assert property (
        cmd != VRCAL_CMD_DES && last_q == 2'h1 |-> since_q >= VRCAL_SET_L_CYC)
        else $error("command before the settle time");
    chk_range_lock: assert property (
        vmr && in_cal_q |-> mr_data[VRCAL_RANGE_BIT] == rng_q)
        else $error("range changed after entry");
    chk_pda_only_mrs: assert property (
        in_cal_q && pda_on |-> cmd inside {VRCAL_CMD_DES, VRCAL_CMD_MRS})
        else $error("non mrs command with per device addressing");
    chk_cal_cmd_set: assert property (
        in_cal_q |-> cmd != VRCAL_CMD_REF)
        else $error("refresh during calibration");
    chk_exit_idle: assert property (
        vmr && in_cal_q && !mr_data[VRCAL_EN_BIT] |-> banks_idle)
        else $error("exit with banks open");
    chk_code_legal: assert property (
        vmr && in_cal_q && mr_data[VRCAL_EN_BIT] |-> mr_data[5:0] <= VRCAL_CODE_MAX)
        else $error("reserved reference code sent");
    chk_mrs_target: assert property (
        cmd == VRCAL_CMD_MRS |-> mr_sel == VRCAL_MR_VREF)
        else $error("mrs to another register");

    // main scenarios
    cover property (vmr && !in_cal_q && mr_data[VRCAL_EN_BIT]);
    cover property (vmr && in_cal_q && mr_data[VRCAL_EN_BIT] && pda_on);
    cover property (vmr && in_cal_q && !mr_data[VRCAL_EN_BIT]);
endmodule
`default_nettype wire

// ### bench/tb_dq_input_reference_calibration_mode_ctl.sv
// testbench: both ends on one link, plus a raw driver facing a second dram end
`timescale 1ns/1ps
`default_nettype none
module tb_dq_input_reference_calibration_mode_ctl;
    import vrcal_pkg::*;
    logic        core_clk  = 1'b0;
    logic        rst       = 1'b1;
    logic        req_valid = 1'b0;
    logic [1:0]  req_op    = 2'h0;
    logic        req_range = 1'b0;
    logic [5:0]  req_code  = 6'h00;
    logic        pda_mode  = 1'b0;
    logic        req_ready, busy;
    logic        act1, val1, rng1, perr1, act2, val2, rng2, perr2;
    logic [5:0]  code1, code2;
    logic [13:0] lvl1, lvl2;
    int          n_fail = 0;
    int          checked = 0;
    int          cyc = 0;
    int          nerr1 = 0;
    int          nerr2 = 0;
    int          base;

    vrcal_if lnk ();
    vrcal_if lnk_b ();

    vrcal_ctl u_vrcal_ctl (.lnk(lnk.ctl), .core_clk(core_clk), .rst(rst),
        .req_valid(req_valid), .req_ready(req_ready), .req_op(req_op),
        .req_range(req_range), .req_code(req_code), .pda_mode(pda_mode), .busy(busy));
    vrcal_dram u_vrcal_dram (.lnk(lnk.dram), .core_clk(core_clk), .rst(rst),
        .cal_active(act1), .ref_range(rng1), .ref_code(code1), .ref_valid(val1),
        .ref_level_cpct(lvl1), .protocol_err(perr1));
    vrcal_dram u_vrcal_dram_b (.lnk(lnk_b.dram), .core_clk(core_clk), .rst(rst),
        .cal_active(act2), .ref_range(rng2), .ref_code(code2), .ref_valid(val2),
        .ref_level_cpct(lvl2), .protocol_err(perr2));
    vrcal_link_sva u_vrcal_link_sva (.link_clk(lnk.link_clk), .link_rst(lnk.link_rst),
        .cmd(lnk.cmd), .mr_sel(lnk.mr_sel), .mr_data(lnk.mr_data), .pda_on(lnk.pda_on),
        .banks_idle(lnk.banks_idle));

    // ************************************************************
    // clocks, timeout and error pulse counters
    // ************************************************************
    always #5 core_clk = ~core_clk;
    always #15 lnk_b.link_clk = ~lnk_b.link_clk;  // free running, no phase tie to core

    // a hang counts as a mismatch
    always @(posedge core_clk)
    begin
        cyc <= cyc + 1;
        if (perr1 === 1'b1) nerr1 <= nerr1 + 1;
        if (perr2 === 1'b1) nerr2 <= nerr2 + 1;
        if (cyc == 6000)
        begin
            n_fail++;
            give_verdict();
        end
    end

    // ************************************************************
    // tasks
    // ************************************************************
    task automatic give_verdict();
        $display("checked %0d n_fail %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task automatic chk(input string what, input logic [22:0] exp, input logic [22:0] got);
        checked++;
        if (got !== exp)
        begin
            n_fail++;
            $display("BAD %s exp %h got %h", what, exp, got);
        end
    endtask

    // expected {active, valid, range, code, level} from the range span table
    function automatic logic [22:0] st(input logic a, input logic v, input logic r,
                                       input logic [5:0] c);
        int lo;
        lo = r ? VRCAL_R2_LO_CPCT : VRCAL_R1_LO_CPCT;
        return {a, v, r, c, 14'(lo + c * VRCAL_STEP_CPCT)};
    endfunction

    // one controller request, held until taken, then wait for the run to end
    task automatic req(input logic [1:0] op, input logic r, input logic [5:0] c);
        @(negedge core_clk);
        req_valid = 1'b1;
        req_op    = op;
        req_range = r;
        req_code  = c;
        #1;
        while (req_ready !== 1'b1)
        begin
            @(negedge core_clk);
            #1;
        end
        @(negedge core_clk);
        req_valid = 1'b0;
        @(negedge core_clk);
        chk("busy", 23'(1), 23'(busy));
        while (busy !== 1'b0) @(negedge core_clk);
    endtask

    // raw command on the second link; data inverted once released
    task automatic send(input vrcal_cmd_t c, input logic [7:0] d);
        @(negedge lnk_b.link_clk);
        lnk_b.cmd     = c;
        lnk_b.mr_sel  = VRCAL_MR_VREF;
        lnk_b.mr_data = d;
        @(negedge lnk_b.link_clk);
        lnk_b.cmd     = VRCAL_CMD_DES;
        lnk_b.mr_data = ~d;
        repeat (10) @(negedge lnk_b.link_clk);
    endtask

    // ************************************************************
    // main sequence
    // ************************************************************
    initial
    begin
        lnk_b.link_clk   = 1'b0;
        lnk_b.link_rst   = 1'b1;
        lnk_b.cmd        = VRCAL_CMD_DES;
        lnk_b.mr_sel     = 3'h0;
        lnk_b.mr_data    = 8'h00;
        lnk_b.pda_on     = 1'b0;
        lnk_b.banks_idle = 1'b1;
        repeat (3) @(negedge core_clk);
        rst = 1'b0;
        repeat (3) @(negedge lnk_b.link_clk);
        lnk_b.link_rst = 1'b0;
        chk("idle after reset", 23'(0), 23'({act1, val1, act2, val2}));

        // test 1: range 1, last code on the top step, range request ignored
        req(2'h0, 1'b0, 6'h2A);
        chk("active", 23'(1), 23'(act1));
        chk("valid in cal", 23'(0), 23'(val1));
        req(2'h1, 1'b0, 6'h10);
        req(2'h1, 1'b1, 6'h32);
        req(2'h2, 1'b0, 6'h00);
        chk("range 1 result", st(0, 1, 0, 6'h32), {act1, val1, rng1, code1, lvl1});
        $display("test 1 done");

        // test 2: range 2 with per device addressing, reserved code clamped
        pda_mode = 1'b1;
        req(2'h0, 1'b1, 6'h00);
        req(2'h1, 1'b1, 6'h00);
        req(2'h1, 1'b1, 6'h3F);
        req(2'h2, 1'b1, 6'h00);
        pda_mode = 1'b0;
        chk("range 2 result", st(0, 1, 1, 6'h32), {act1, val1, rng1, code1, lvl1});
        chk("legal link errors", 23'(0), 23'(nerr1));
        $display("test 2 done");

        // test 3: raw driver, entry code ignored, faults flagged, exit keeps bits
        send(VRCAL_CMD_MRS, 8'hEA);
        chk("b active", 23'(2), 23'({act2, val2}));
        send(VRCAL_CMD_WR, 8'h00);
        chk("dummy write", 23'(0), 23'(nerr2));
        send(VRCAL_CMD_MRS, 8'h91);
        chk("range change flagged", 23'(1), 23'(nerr2));
        send(VRCAL_CMD_MRS, 8'hC3);
        base = nerr2;
        lnk_b.pda_on = 1'b1;
        send(VRCAL_CMD_ACT, 8'h00);
        chk("pda act flagged", 23'(1), 23'(nerr2 - base));
        lnk_b.pda_on = 1'b0;
        send(VRCAL_CMD_REF, 8'h00);
        chk("refresh flagged", 23'(2), 23'(nerr2 - base));
        lnk_b.banks_idle = 1'b0;
        send(VRCAL_CMD_MRS, 8'h55);
        chk("open bank exit flagged", 23'(3), 23'(nerr2 - base));
        lnk_b.banks_idle = 1'b1;
        send(VRCAL_CMD_MRS, 8'h55);
        chk("b exit", st(0, 1, 1, 6'h03), {act2, val2, rng2, code2, lvl2});
        send(VRCAL_CMD_MRS, 8'h2A);
        chk("b write off", st(0, 1, 1, 6'h03), {act2, val2, rng2, code2, lvl2});
        $display("test 3 done");
        give_verdict();
    end
endmodule
`default_nettype wire
